// [qafc_pkg.sv]
// package: constants and carriers for the quad converter serial frame control
package qafc_pkg;
    localparam int unsigned FRAME_CYCLES     = 16;
    localparam int unsigned TRACK_CYCLES     = 3;
    localparam int unsigned HOLD_CYCLES      = 13;
    localparam int unsigned RESULT_BITS      = 10;
    localparam int unsigned CTRL_BITS        = 8;
    localparam logic [3:0]  FIRST_DATA_EDGE  = 4'h4;
    localparam logic [3:0]  LAST_DATA_EDGE   = 4'hd;
    localparam logic [3:0]  LAST_TRACK_EDGE  = 4'h2;
    localparam logic [3:0]  LAST_CTRL_EDGE   = 4'h7;
    localparam logic [3:0]  LAST_EDGE        = 4'hf;
    localparam int unsigned CH_FIELD_LO      = 3;
    localparam int unsigned CH_FIELD_HI      = 5;
    localparam logic [1:0]  CH_RESET         = 2'h0;

    typedef enum logic [1:0] {
        QAFC_IDLE  = 2'b00,
        QAFC_TRACK = 2'b01,
        QAFC_HOLD  = 2'b10,
        QAFC_GAP   = 2'b11
    } qafc_phase_e;

    typedef struct packed {
        logic [1:0] channel;
        logic [9:0] code;
    } qafc_result_s;
endpackage : qafc_pkg

// [qafc_buf.sv]
// module: two-entry valid/ready buffer for conversion results
module qafc_buf (
    input  wire logic                   clk_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   in_valid_i,
    output logic                        in_ready_o,
    input  wire qafc_pkg::qafc_result_s in_data_i,
    output logic                        out_valid_o,
    input  wire logic                   out_ready_i,
    output qafc_pkg::qafc_result_s      out_data_o
);
    import qafc_pkg::*;
    qafc_result_s mem_q [2];
    qafc_result_s mem_d [2];
    logic         wr_q, wr_d, rd_q, rd_d;
    logic [1:0]   cnt_q, cnt_d;
    logic         push, pop;

    assign in_ready_o  = (cnt_q != 2'h2);
    assign out_valid_o = (cnt_q != 2'h0);
    assign out_data_o  = mem_q[rd_q];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_comb begin
        mem_d = mem_q;
        wr_d  = wr_q;
        rd_d  = rd_q;
        cnt_d = cnt_q;
        if (push) begin
            mem_d[wr_q] = in_data_i;
            wr_d        = ~wr_q;
        end
        if (pop) begin
            rd_d = ~rd_q;
        end
        if (push && !pop) begin
            cnt_d = cnt_q + 2'h1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 2'h1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
            wr_q     <= 1'b0;
            rd_q     <= 1'b0;
            cnt_q    <= 2'h0;
        end else begin
            mem_q <= mem_d;
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end
endmodule : qafc_buf

// [qafc_top.sv]
// module: serial frame sequencing of a four-channel 10-bit successive-approximation converter
// How it works
// - frame spans strobe low interval
// - track for first three cycles
// - hold, convert, shift for thirteen cycles
// - result MSB first from fifth cycle
// - retrack after each sixteenth rising edge
// - hold again at fourth falling edge
// - output enabled only while strobe low
// - power down when strobe high, between conversions
// - clock gated off while strobe high
// - strobe fall with clock low starts track
// - clock high: track at first fall
// - control sampled on first eight rising edges
// - captured channel applies to next conversion
// - channel field is control bits five to three
// - low two field bits pick input
// - channel resets to input zero
// - simultaneous fall: counts as first falling edge, track at once
module qafc_top (
    input  wire logic              MCLK_I,
    input  wire logic              RST_N_I,
    input  wire logic              CS_N_I,
    input  wire logic              SCLK_I,
    input  wire logic              SDI_I,
    output logic                   SDO_O,
    output logic                   SDO_OE_O,
    output logic                   TRACK_O,
    output logic                   POWER_DOWN_O,
    output logic [1:0]             MUX_SEL_O,
    output logic                   SAMPLE_REQ_O,
    input  wire logic [9:0]        SAMPLE_CODE_I,
    output logic                   RESULT_VALID_O,
    input  wire logic              RESULT_READY_I,
    output qafc_pkg::qafc_result_s RESULT_O
);
    import qafc_pkg::*;
    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [1:0] cs_s_q, sclk_s_q, sdi_s_q;
    logic       cs_n, sclk_r_q, cs_r_q;
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            cs_s_q   <= 2'h3;
            sclk_s_q <= 2'h0;
            sdi_s_q  <= 2'h0;
            sclk_r_q <= 1'b0;
            cs_r_q   <= 1'b1;
        end else begin
            cs_s_q   <= {cs_s_q[0], CS_N_I};
            sclk_s_q <= {sclk_s_q[0], SCLK_I};
            sdi_s_q  <= {sdi_s_q[0], SDI_I};
            sclk_r_q <= sclk_s_q[1];
            cs_r_q   <= cs_s_q[1];
        end
    end
    assign cs_n = cs_s_q[1];

    // ****************************************
    // internal serial clock edges
    // ****************************************
    logic sclk_int, sclk_int_prev, rise, fall;
    // gated copy: forced high while strobe high, so a strobe fall with clock low is a falling edge
    assign sclk_int      = cs_n | sclk_s_q[1];
    assign sclk_int_prev = cs_r_q | sclk_r_q;
    assign rise          = !cs_n && sclk_int && !sclk_int_prev;
    assign fall          = !cs_n && !sclk_int && sclk_int_prev;

    // ****************************************
    // conversion sequencer
    // ****************************************
    function automatic logic [1:0] chan_of(input logic [7:0] w);
        return w[CH_FIELD_HI-1:CH_FIELD_LO];
    endfunction : chan_of

    qafc_phase_e  ph_q, ph_d;
    logic [3:0]   fcnt_q, fcnt_d;       // falling edges seen in this conversion
    logic [3:0]   rcnt_q, rcnt_d;       // rising edges seen in this conversion
    logic [7:0]   ctrl_q, ctrl_d;
    logic [1:0]   ch_q, ch_d, cur_ch_q, cur_ch_d;
    logic [9:0]   sh_q, sh_d;
    logic         sdo_q, sdo_d;
    logic         sreq_q, sreq_d;
    logic         push_q, push_d;
    logic         pend_q, pend_d;
    qafc_result_s res_q, res_d;
    logic         buf_ready;

    always_comb begin
        ph_d     = ph_q;
        fcnt_d   = fcnt_q;
        rcnt_d   = rcnt_q;
        ctrl_d   = ctrl_q;
        ch_d     = ch_q;
        cur_ch_d = cur_ch_q;
        sh_d     = sh_q;
        sdo_d    = sdo_q;
        sreq_d   = 1'b0;
        push_d   = 1'b0;
        pend_d   = pend_q;
        res_d    = res_q;
        if (pend_q && buf_ready) begin
            push_d = 1'b1;
            pend_d = 1'b0;
        end
        if (cs_n) begin
            ph_d   = QAFC_IDLE;
            fcnt_d = 4'h0;
            rcnt_d = 4'h0;
            sdo_d  = 1'b0;
        end else begin
            if (fall) begin
                case (ph_q)
                    QAFC_IDLE, QAFC_GAP: begin
                        // first falling edge of a conversion opens track
                        ph_d     = QAFC_TRACK;
                        fcnt_d   = 4'h1;
                        cur_ch_d = ch_q;
                        sdo_d    = 1'b0;
                    end
                    QAFC_TRACK: begin
                        fcnt_d = fcnt_q + 4'h1;
                        if (fcnt_q == LAST_TRACK_EDGE + 4'h1) begin
                            ph_d   = QAFC_HOLD;
                            sreq_d = 1'b1;
                        end
                    end
                    QAFC_HOLD: begin
                        fcnt_d = fcnt_q + 4'h1;
                        if (fcnt_q >= FIRST_DATA_EDGE && fcnt_q <= LAST_DATA_EDGE) begin
                            sdo_d = sh_q[RESULT_BITS-1];
                            sh_d  = {sh_q[RESULT_BITS-2:0], 1'b0};
                        end else begin
                            sdo_d = 1'b0;
                        end
                    end
                    default: begin
                        ph_d = QAFC_IDLE;
                    end
                endcase
            end
            if (ph_q == QAFC_HOLD && fcnt_q == FIRST_DATA_EDGE && !fall && sreq_q) begin
                sh_d = SAMPLE_CODE_I;
            end
            if (rise && ph_q != QAFC_IDLE && ph_q != QAFC_GAP) begin
                // rises before the first internal fall are not counted
                rcnt_d = rcnt_q + 4'h1;
                if (rcnt_q <= LAST_CTRL_EDGE) begin
                    ctrl_d = {ctrl_q[CTRL_BITS-2:0], sdi_s_q[1]};
                end
                if (rcnt_q == LAST_CTRL_EDGE) begin
                    ch_d = chan_of({ctrl_q[CTRL_BITS-2:0], sdi_s_q[1]});
                end
                if (rcnt_q == LAST_EDGE) begin
                    ph_d   = QAFC_GAP;
                    rcnt_d = 4'h0;
                    fcnt_d = 4'h0;
                    res_d  = '{channel: cur_ch_q, code: SAMPLE_CODE_I};
                    pend_d = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ph_q     <= QAFC_IDLE;
            fcnt_q   <= 4'h0;
            rcnt_q   <= 4'h0;
            ctrl_q   <= 8'h00;
            ch_q     <= CH_RESET;
            cur_ch_q <= CH_RESET;
            sh_q     <= 10'h000;
            sdo_q    <= 1'b0;
            sreq_q   <= 1'b0;
            push_q   <= 1'b0;
            pend_q   <= 1'b0;
            res_q    <= '0;
        end else begin
            ph_q     <= ph_d;
            fcnt_q   <= fcnt_d;
            rcnt_q   <= rcnt_d;
            ctrl_q   <= ctrl_d;
            ch_q     <= ch_d;
            cur_ch_q <= cur_ch_d;
            sh_q     <= sh_d;
            sdo_q    <= sdo_d;
            sreq_q   <= sreq_d;
            push_q   <= push_d;
            pend_q   <= pend_d;
            res_q    <= res_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign SDO_O        = sdo_q;
    assign SDO_OE_O     = !cs_n;
    assign TRACK_O      = (ph_q == QAFC_TRACK);
    assign POWER_DOWN_O = (ph_q == QAFC_IDLE) || (ph_q == QAFC_GAP);
    assign MUX_SEL_O    = (ph_q == QAFC_TRACK) ? cur_ch_q : ch_q;
    assign SAMPLE_REQ_O = sreq_q;

    // a stalled reader holds up to two results plus one pending; further results overwrite the pending one
    qafc_buf u_buf (
        .clk_i       (MCLK_I),
        .rst_n_i     (RST_N_I),
        .in_valid_i  (push_q),
        .in_ready_o  (buf_ready),
        .in_data_i   (res_q),
        .out_valid_o (RESULT_VALID_O),
        .out_ready_i (RESULT_READY_I),
        .out_data_o  (RESULT_O)
    );
endmodule : qafc_top

// [qafc_monitor.sv]
// checker: port-level assertions for the serial frame control
module qafc_monitor (
    input wire logic                   MCLK_I,
    input wire logic                   RST_N_I,
    input wire logic                   CS_N_I,
    input wire logic                   SDO_O,
    input wire logic                   SDO_OE_O,
    input wire logic                   TRACK_O,
    input wire logic                   POWER_DOWN_O,
    input wire logic [1:0]             MUX_SEL_O,
    input wire logic                   SAMPLE_REQ_O,
    input wire logic                   RESULT_VALID_O,
    input wire logic                   RESULT_READY_I,
    input wire qafc_pkg::qafc_result_s RESULT_O
);
    import qafc_pkg::*;
    // ********************
    // strobe and phases
    // ********************
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RST_N_I);
    // strobe lengths cover the two sync flops plus the state register
    sequence cs_idle; CS_N_I [*5]; endsequence
    sequence cs_act; !CS_N_I [*3]; endsequence
    sequence stall; RESULT_VALID_O && !RESULT_READY_I; endsequence
    oe_off_a: assert property (cs_idle |=> !SDO_OE_O) else $error("sdo enabled while idle");
    oe_on_a: assert property (cs_act |=> SDO_OE_O) else $error("sdo not enabled in frame");
    trk_idle_a: assert property (cs_idle |=> !TRACK_O && POWER_DOWN_O && !SDO_O)
        else $error("activity while strobe high");
    req_pulse_a: assert property (SAMPLE_REQ_O |=> !SAMPLE_REQ_O && !TRACK_O) else $error("bad hold entry");
    req_trk_a: assert property (SAMPLE_REQ_O |-> TRACK_O || $past(TRACK_O)) else $error("hold without track");
    trk_pd_a: assert property (TRACK_O |-> !POWER_DOWN_O && !SDO_O) else $error("track state wrong");
    trk_frame_a: assert property ($rose(TRACK_O) |-> !CS_N_I) else $error("track outside frame");
    mux_a: assert property (TRACK_O && $past(TRACK_O) |-> $stable(MUX_SEL_O)) else $error("mux moved");
    hold_a: assert property (stall |=> RESULT_VALID_O && $stable(RESULT_O)) else $error("result lost");
endmodule : qafc_monitor

bind qafc_top qafc_monitor i_mon (.MCLK_I, .RST_N_I, .CS_N_I, .SDO_O, .SDO_OE_O, .TRACK_O, .POWER_DOWN_O,
    .MUX_SEL_O, .SAMPLE_REQ_O, .RESULT_VALID_O, .RESULT_READY_I, .RESULT_O);

// [qafc_host.sv]
// partner: serial host that frames conversions and shifts control words in
module qafc_host (
    input  wire logic clk_i,
    input  wire logic sdo_i,
    output logic      cs_n_o,
    output logic      sclk_o,
    output logic      sdi_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ********************
    // frame generator
    // ********************
    localparam int HALF = 6; // well above the 3-cycle edge detect
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        sdi_o = 1'b0;
    end
    // w holds the control words of up to two conversions, first in the top byte
    task automatic frame(input int n, input logic hi, input logic [15:0] w, output logic [31:0] rx);
        rx = '0;
        @(posedge clk_i);
        sclk_o <= hi;
        repeat (HALF) @(posedge clk_i);
        cs_n_o <= 1'b0;
        for (int c = 0; c < n; c++) begin
            for (int e = 1; e <= 16; e++) begin
                if (e > 1 || c > 0 || hi) begin
                    repeat (HALF) @(posedge clk_i);
                    sclk_o <= 1'b0;
                end
                // past the control bits the line toggles so a stray capture shows
                sdi_o <= (e <= 8) ? w[16-8*c-e] : ~sdi_o;
                repeat (HALF) @(posedge clk_i);
                sclk_o <= 1'b1;
                rx = {rx[30:0], sdo_i};
            end
        end
        repeat (HALF) @(posedge clk_i);
        cs_n_o <= 1'b1;
        repeat (HALF) @(posedge clk_i);
        sclk_o <= 1'b0;
    endtask : frame
endmodule : qafc_host

// [tb_top.sv]
// testbench: host frames, analog stand-in and result stream checks
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import qafc_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic ready = 1'b0;
    logic [9:0] code = '0;
    logic cs_n, sclk, sdi, sdo, valid, req, trk;
    logic [1:0] mux;
    logic [31:0] rx;
    qafc_result_s res;
    int bad_count = 0;
    int checked = 0;
    logic [9:0] tbl [4] = '{10'h2a5, 10'h15a, 10'h3c3, 10'h0f0};
    always #25 mclk = ~mclk;
    // analog core stand-in: a fixed code per channel makes the channel visible;
    // it follows the mux while tracking, so the code already stands while the sample request is up
    always @(posedge mclk) if (trk || req) code <= tbl[mux];
    qafc_host i_host (.clk_i(mclk), .sdo_i(sdo), .cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi));
    qafc_top i_dut (.MCLK_I(mclk), .RST_N_I(rst_n), .CS_N_I(cs_n), .SCLK_I(sclk), .SDI_I(sdi), .SDO_O(sdo),
        .SDO_OE_O(), .TRACK_O(trk), .POWER_DOWN_O(), .MUX_SEL_O(mux), .SAMPLE_REQ_O(req),
        .SAMPLE_CODE_I(code), .RESULT_VALID_O(valid), .RESULT_READY_I(ready), .RESULT_O(res));
    // ********************
    // checking tasks
    // ********************
    task automatic conclude();
        if (bad_count == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude
    task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask : cmp
    function automatic logic [15:0] word(input logic [1:0] ch);
        return {4'h0, tbl[ch], 2'h0};
    endfunction : word
    task automatic pop(input logic [1:0] ch);
        int i;
        i = 0;
        do begin
            @(negedge mclk);
            i++;
        end while (valid !== 1'b1 && i < 400);
        if (i >= 400) begin
            bad_count++;
            conclude();
        end
        cmp("result", {4'h0, ch, tbl[ch]}, {4'h0, res});
        @(posedge mclk);
        ready <= 1'b1;
        @(posedge mclk);
        ready <= 1'b0;
    endtask : pop
    // ********************
    // scenarios
    // ********************
    task automatic s_first();
        i_host.frame(1, 1'b0, 16'hdb00, rx);
        cmp("sdo first", word(2'h0), rx[15:0]);
        pop(2'h0);
    endtask : s_first
    // two conversions in one frame with the sink stalled throughout
    task automatic s_back();
        i_host.frame(2, 1'b1, 16'h28d0, rx);
        cmp("sdo conv0", word(2'h3), rx[31:16]);
        cmp("sdo conv1", word(2'h1), rx[15:0]);
        pop(2'h3);
        pop(2'h1);
        // the last pop lands on the edge that ended pop, so look half a cycle later
        @(negedge mclk);
        cmp("drained", 16'h0, {15'h0, valid});
    endtask : s_back
    task automatic s_chan();
        logic [1:0] prev;
        prev = 2'h2;
        for (int c = 0; c < 4; c++) begin
            i_host.frame(1, 1'b0, {2'b11, 1'b1, c[1:0], 3'b010, 8'h00}, rx);
            cmp("sdo chan", word(prev), rx[15:0]);
            pop(prev);
            prev = c[1:0];
        end
    endtask : s_chan
    initial begin
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        s_first();
        s_back();
        s_chan();
        conclude();
    end
endmodule : tb_top
